// >>> rtl/pic_defs.vh
// Constants for the prioritized interrupt controller and core context logic.
// Assumes inclusion by bare name from rtl modules.
`ifndef PIC_DEFS_VH
`define PIC_DEFS_VH
// Register offsets on the plain register port
`define PIC_ADDR_PEND      4'h0
`define PIC_ADDR_MASK      4'h1
`define PIC_ADDR_TRIG      4'h2
`define PIC_ADDR_CODE      4'h3
`define PIC_ADDR_STATE     4'h4
`define PIC_ADDR_SRET      4'h5
`define PIC_ADDR_SSTATE    4'h6
`define PIC_ADDR_ENWR      4'h7
`define PIC_ADDR_OFFWR     4'h8
`define PIC_ADDR_UNRWR     4'h9
`define PIC_ADDR_BRIDGE    4'hA
// Reset values
`define PIC_MASK_RST       16'h0000
`define PIC_TRIG_RST       8'h00
`define PIC_STATE_RST      32'h0000_0000
`define PIC_CODE_IDLE      6'h3C
// Vectors
`define PIC_VEC_EXT        32'h0000_0500
`define PIC_VEC_NMI        32'h0000_0100
// State word bit positions (bit 0 is the MSB-numbered bit 31 here: index = 31 - n)
`define PIC_SW_EE          15
`define PIC_SW_PR          14
`define PIC_SW_FP          13
`define PIC_SW_FE0         11
`define PIC_SW_SE          10
`define PIC_SW_BE          9
`define PIC_SW_FE1         8
`define PIC_SW_IP          6
`define PIC_SW_RI          1
`define PIC_SW_LE          0
// Entry clear mask over bits 16:31 (low half of the word)
`define PIC_SW_ENTRY_CLR   16'hEF03
`define PIC_EXC_INFO_EXT   16'h0000
`define PIC_EXC_INFO_NMI   16'h0001
// Bridge propagation delays
`define PIC_BRIDGE_FULL    4'h6
`define PIC_BRIDGE_HALF    4'hC
`endif

// >>> rtl/pic_ctrl.v
// Sixteen-input prioritized interrupt controller with core entry/return context.
// Assumes one 250 MHz clock, synchronous reset, request pins asynchronous.
`timescale 1ns/1ps
`include "pic_defs.vh"
module pic_ctrl #(
  parameter NPIN = 8
) (
  // Clock and reset
  input  wire        clock_i,
  input  wire        reset_i,
  // Sources
  input  wire [7:0]  irq_pin_n_i,
  input  wire [7:0]  int_src_req_i,
  input  wire [63:0] int_src_lvl_i,
  input  wire [31:0] bridge_lvl_req_i,
  // Core handshake
  input  wire        core_idle_i,
  input  wire [31:0] next_pc_i,
  input  wire        rfi_i,
  output reg         core_irq_o,
  output reg         fetch_load_o,
  output reg  [31:0] fetch_addr_o,
  output wire [31:0] state_word_o,
  // Register port
  input  wire [3:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o
);
  // ************************************************************
  // Pin synchronisers and trigger logic
  // ************************************************************
  reg  [7:0]  pin_s1_q;
  reg  [7:0]  pin_s2_q;
  reg  [7:0]  pin_prev_q;
  reg  [15:0] pend_q;
  reg  [15:0] mask_q;
  reg  [7:0]  trig_q;
  reg         half_rate_q;
  reg  [31:0] state_q;
  reg  [31:0] sret_q;
  reg  [31:0] sstate_q;
  reg  [7:0]  lvl_pipe_q [0:11];
  reg         nmi_seen_q;
  integer     i;

  wire [7:0] trig_eff = {trig_q[7:1], 1'b1};
  wire [7:0] fall     = pin_prev_q & ~pin_s2_q;

  // ************************************************************
  // Internal level assembly
  // ************************************************************
  reg [7:0] lvl_now;
  always @* begin
    lvl_now = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      // Byte i selects level by one-hot, MSB is level 0
      lvl_now = lvl_now | (int_src_req_i[i] ? {int_src_lvl_i[8*i],
        int_src_lvl_i[8*i+1], int_src_lvl_i[8*i+2], int_src_lvl_i[8*i+3],
        int_src_lvl_i[8*i+4], int_src_lvl_i[8*i+5], int_src_lvl_i[8*i+6],
        int_src_lvl_i[8*i+7]} : 8'h00);
    end
    lvl_now[6:0] = lvl_now[6:0] | bridge_lvl_req_i[6:0];
    lvl_now[7]   = lvl_now[7] | (|bridge_lvl_req_i[31:7]);
  end

  // Bridge sources take six or twelve clocks to reach the controller
  wire [3:0] bdly = half_rate_q ? `PIC_BRIDGE_HALF : `PIC_BRIDGE_FULL;
  wire [7:0] lvl_in = lvl_pipe_q[bdly - 4'h1];

  // ************************************************************
  // Priority encoder
  // ************************************************************
  // Vector index 2n is pin n, 2n+1 is level n
  function [5:0] pic_code;
    input [15:0] act;
    integer k;
    begin
      pic_code = `PIC_CODE_IDLE;
      for (k = 15; k >= 0; k = k - 1)
        if (act[k])
          pic_code = k[3:0] * 6'h4;
    end
  endfunction

  wire [15:0] mask_eff = {mask_q[15:1], 1'b1};
  wire [15:0] active   = pend_q & mask_eff;
  wire [5:0]  code     = pic_code(active);
  wire        any_req  = |active;
  wire        ee       = state_q[`PIC_SW_EE];
  wire        take     = any_req & ee & core_idle_i;
  wire        take_nmi = active[0] & core_idle_i & ~nmi_seen_q;

  assign state_word_o = state_q;

  // ************************************************************
  // Register write decode
  // ************************************************************
  // One compare shared by every target keeps the map in one place
  function pic_hit;
    input [3:0] a;
    input [3:0] target;
    begin
      pic_hit = (a == target);
    end
  endfunction

  wire        wr_pend   = wr_i & pic_hit(addr_i, `PIC_ADDR_PEND);
  wire        wr_mask   = wr_i & pic_hit(addr_i, `PIC_ADDR_MASK);
  wire        wr_trig   = wr_i & pic_hit(addr_i, `PIC_ADDR_TRIG);
  wire        wr_bridge = wr_i & pic_hit(addr_i, `PIC_ADDR_BRIDGE);
  wire        wr_state  = wr_i & pic_hit(addr_i, `PIC_ADDR_STATE);
  wire        wr_sret   = wr_i & pic_hit(addr_i, `PIC_ADDR_SRET);
  wire        wr_sstate = wr_i & pic_hit(addr_i, `PIC_ADDR_SSTATE);
  wire        wr_en     = wr_i & pic_hit(addr_i, `PIC_ADDR_ENWR);
  wire        wr_off    = wr_i & pic_hit(addr_i, `PIC_ADDR_OFFWR);
  wire        wr_unr    = wr_i & pic_hit(addr_i, `PIC_ADDR_UNRWR);
  wire        enter     = take_nmi | take;
  integer     j;
  integer     m;

  // ************************************************************
  // Input capture
  // ************************************************************
  always @(posedge clock_i) begin
    if (reset_i) begin
      pin_s1_q   <= 8'hFF;
      pin_s2_q   <= 8'hFF;
      pin_prev_q <= 8'hFF;
    end else begin
      pin_s1_q   <= irq_pin_n_i;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // Delay line models the bridge; the tap picks full or half rate
  always @(posedge clock_i) begin
    if (reset_i) begin
      for (j = 0; j < 12; j = j + 1)
        lvl_pipe_q[j] <= 8'h00;
    end else begin
      lvl_pipe_q[0] <= lvl_now;
      for (j = 1; j < 12; j = j + 1)
        lvl_pipe_q[j] <= lvl_pipe_q[j-1];
    end
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      mask_q      <= `PIC_MASK_RST;
      trig_q      <= `PIC_TRIG_RST;
      half_rate_q <= 1'b0;
    end else begin
      if (wr_mask)
        mask_q <= wdata_i[15:0];
      if (wr_trig)
        trig_q <= wdata_i[7:0];
      if (wr_bridge)
        half_rate_q <= wdata_i[0];
    end
  end

  // Pending bits; an edge in the clear cycle wins so no event is lost
  always @(posedge clock_i) begin
    if (reset_i) begin
      pend_q <= 16'h0000;
    end else begin
      for (m = 0; m < 8; m = m + 1) begin
        if (trig_eff[m]) begin
          if (fall[m])
            pend_q[2*m] <= 1'b1;
          else if (wr_pend && wdata_i[2*m])
            pend_q[2*m] <= 1'b0;
        end else begin
          pend_q[2*m] <= ~pin_s2_q[m];
        end
        pend_q[2*m+1] <= lvl_in[m];
      end
    end
  end

  // ************************************************************
  // Core context switch
  // ************************************************************
  // Held while pin 0 stays pending, so one assertion gives one entry
  always @(posedge clock_i) begin
    if (reset_i)
      nmi_seen_q <= 1'b0;
    else if (enter)
      nmi_seen_q <= nmi_seen_q | take_nmi;
    else if (!active[0])
      nmi_seen_q <= 1'b0;
  end

  always @(posedge clock_i) begin
    if (reset_i)
      core_irq_o <= 1'b0;
    else
      core_irq_o <= any_req & ee;
  end

  // Entry and return override a software write to bits 15:0 in the same cycle
  always @(posedge clock_i) begin
    if (reset_i) begin
      state_q <= `PIC_STATE_RST;
    end else begin
      if (wr_state)
        state_q <= wdata_i;
      if (wr_en) begin
        state_q[`PIC_SW_RI] <= 1'b1;
        state_q[`PIC_SW_EE] <= 1'b1;
      end
      if (wr_off) begin
        state_q[`PIC_SW_RI] <= 1'b1;
        state_q[`PIC_SW_EE] <= 1'b0;
      end
      if (wr_unr) begin
        state_q[`PIC_SW_RI] <= 1'b0;
        state_q[`PIC_SW_EE] <= 1'b0;
      end
      if (enter)
        state_q[15:0] <= state_q[15:0] & ~`PIC_SW_ENTRY_CLR;
      else if (rfi_i)
        state_q[15:0] <= sstate_q[15:0];
    end
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      sret_q   <= 32'h0000_0000;
      sstate_q <= 32'h0000_0000;
    end else begin
      if (wr_sret)
        sret_q <= wdata_i;
      if (wr_sstate)
        sstate_q <= wdata_i;
      if (enter) begin
        sret_q          <= next_pc_i;
        sstate_q[31:16] <= take_nmi ? `PIC_EXC_INFO_NMI
                                    : `PIC_EXC_INFO_EXT;
        sstate_q[15:0]  <= state_q[15:0];
      end
    end
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      fetch_load_o <= 1'b0;
      fetch_addr_o <= 32'h0000_0000;
    end else if (enter) begin
      fetch_load_o <= 1'b1;
      fetch_addr_o <= take_nmi ? `PIC_VEC_NMI : `PIC_VEC_EXT;
    end else if (rfi_i) begin
      fetch_load_o <= 1'b1;
      fetch_addr_o <= sret_q;
    end else begin
      fetch_load_o <= 1'b0;
    end
  end

  // ************************************************************
  // Register read
  // ************************************************************
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (addr_i)
      `PIC_ADDR_PEND:   rd_mux = {16'h0000, pend_q};
      `PIC_ADDR_MASK:   rd_mux = {16'h0000, mask_q};
      `PIC_ADDR_TRIG:   rd_mux = {24'h000000, trig_q};
      `PIC_ADDR_CODE:   rd_mux = {26'h0000000, code};
      `PIC_ADDR_STATE:  rd_mux = state_q;
      `PIC_ADDR_SRET:   rd_mux = sret_q;
      `PIC_ADDR_SSTATE: rd_mux = sstate_q;
      `PIC_ADDR_BRIDGE: rd_mux = {31'h00000000, half_rate_q};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data stand one cycle after the strobe and are zero otherwise
  always @(posedge clock_i) begin
    if (reset_i)
      rdata_o <= 32'h0000_0000;
    else if (rd_i)
      rdata_o <= rd_mux;
    else
      rdata_o <= 32'h0000_0000;
  end
endmodule // pic_ctrl

// >>> sim/pic_ctrl_monitor.sv
// Port checker for the interrupt controller and core context logic.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "pic_defs.vh"
module pic_ctrl_chk (
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic        core_idle_i,
  input wire logic        rfi_i,
  input wire logic [3:0]  addr_i,
  input wire logic        rd_i,
  input wire logic        core_irq_o,
  input wire logic        fetch_load_o,
  input wire logic [31:0] fetch_addr_o,
  input wire logic [31:0] state_word_o,
  input wire logic [31:0] rdata_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  a_rd_quiet: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not idle");
  a_load_pulse: assert property (fetch_load_o |=> !fetch_load_o)
    else $error("fetch load longer than one cycle");
  a_code_align: assert property ($past(rd_i && addr_i == `PIC_ADDR_CODE) |->
    rdata_o[31:6] == 26'h0 && rdata_o[1:0] == 2'h0) else $error("code misaligned");
  a_unmapped_zero: assert property ($past(rd_i && addr_i > 4'hA) |-> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_irq_needs_ee: assert property (!$past(state_word_o[15]) && !state_word_o[15] |->
    !core_irq_o) else $error("request while enable clear");
  a_entry_clears: assert property (fetch_load_o && fetch_addr_o == `PIC_VEC_EXT |->
    (state_word_o[15:0] & `PIC_SW_ENTRY_CLR) == 16'h0000)
    else $error("entry left state bits set");
  a_entry_idle: assert property (fetch_load_o && fetch_addr_o == `PIC_VEC_EXT |->
    $past(core_idle_i)) else $error("entry while core busy");
  a_return_load: assert property (rfi_i |-> ##[1:3] fetch_load_o)
    else $error("no fetch after return");
endmodule // pic_ctrl_chk
bind pic_ctrl pic_ctrl_chk chk_u (.clock_i(clock_i), .reset_i(reset_i),
  .core_idle_i(core_idle_i), .rfi_i(rfi_i), .addr_i(addr_i), .rd_i(rd_i),
  .core_irq_o(core_irq_o), .fetch_load_o(fetch_load_o), .fetch_addr_o(fetch_addr_o),
  .state_word_o(state_word_o), .rdata_o(rdata_o));

// >>> sim/pic_core_model.sv
// Behavioural core: idle reporting, fixed next address, return pulse.
// Assumes the bench selects slow mode and requests returns.
`timescale 1ns/1ps
module pic_core_model #(
  parameter logic [31:0] PC = 32'h0000_2468
) (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        slow_i,
  input  wire logic        ret_i,
  output logic             idle_o,
  output logic [31:0]      pc_o,
  output logic             rfi_o
);
  logic [1:0] tick_q;
  // Slow mode keeps instructions in flight three cycles out of four
  assign idle_o = !slow_i || (tick_q == 2'h3);
  assign pc_o   = PC;
  always @(posedge clock_i) begin
    tick_q <= reset_i ? 2'h0 : tick_q + 2'h1;
    rfi_o  <= !reset_i && ret_i;
  end
endmodule // pic_core_model

// >>> sim/prioritized_irq_controller_tb_top.sv
// Self-checking bench for the controller, its registers and core entry.
// Assumes the core model answers with a fixed next address.
`timescale 1ns/1ps
`include "pic_defs.vh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin miscompares++; \
  $display("FAIL %s exp %h got %h", n, e, s); end end
module prioritized_irq_controller_tb_top;
  localparam logic [31:0] PC = 32'h0000_2468;
  logic clock_i = 1'b0, reset_i = 1'b1, wr = 1'b0, rd = 1'b0, slow = 1'b0, ret = 1'b0;
  logic idle, rfi, irq, load;
  logic [7:0]  pin_n = 8'hFF, src_req = 8'h00;
  logic [63:0] src_lvl = 64'h0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] br = 32'h0, wdata = 32'h0, next_pc, fetch_addr, state_word, rdata, d;
  int miscompares = 0, n_compared = 0;
  pic_ctrl dut_u (.clock_i(clock_i), .reset_i(reset_i), .irq_pin_n_i(pin_n),
    .int_src_req_i(src_req), .int_src_lvl_i(src_lvl), .bridge_lvl_req_i(br),
    .core_idle_i(idle), .next_pc_i(next_pc), .rfi_i(rfi), .core_irq_o(irq),
    .fetch_load_o(load), .fetch_addr_o(fetch_addr), .state_word_o(state_word),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
  pic_core_model #(.PC(PC)) core_u (.clock_i(clock_i), .reset_i(reset_i), .slow_i(slow),
    .ret_i(ret), .idle_o(idle), .pc_o(next_pc), .rfi_o(rfi));
  always #2 clock_i = ~clock_i;
  task automatic go(input int n); repeat (n) @(posedge clock_i); endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock_i); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clock_i); wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock_i); addr <= a; rd <= 1'b1;
    @(posedge clock_i); rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bounded wait for the vector load, then its address
  task automatic wait_load(input logic [31:0] v);
    int i;
    for (i = 0; i < 60 && load !== 1'b1; i++) begin @(posedge clock_i); #1; end
    if (i == 60) begin miscompares++; $display("FAIL fetch_load exp 1 got 0"); close_out(); end
    `CHK("fetch_addr", v, fetch_addr)
  endtask
  task automatic t_reset;
    rd_reg(`PIC_ADDR_MASK, d); `CHK("mask", 32'h0, d)
    rd_reg(`PIC_ADDR_CODE, d); `CHK("code", 32'h3C, d)
    rd_reg(4'hF, d); `CHK("unmapped", 32'h0, d)
  endtask
  // One source at a time: pins on even vector indices, levels on odd
  task automatic t_codes;
    wr_reg(`PIC_ADDR_MASK, 32'hFFFF);
    for (int k = 1; k < 16; k++) begin
      go(1);
      if (k[0]) begin src_req <= 8'h01; src_lvl <= 64'h80 >> (k >> 1); end
      else pin_n <= ~(8'h01 << (k >> 1));
      go(16); rd_reg(`PIC_ADDR_CODE, d); `CHK("code", 32'(k * 4), d)
      rd_reg(`PIC_ADDR_PEND, d); `CHK("pend", 1'b1, d[k])
      go(1); src_req <= 8'h00; pin_n <= 8'hFF; go(16);
      rd_reg(`PIC_ADDR_PEND, d); `CHK("pend_off", 1'b0, d[k])
    end
  endtask
  task automatic t_prio;
    go(1); pin_n <= 8'hF7; br <= 32'h0010_0002;
    go(16); rd_reg(`PIC_ADDR_CODE, d); `CHK("code", 32'h0C, d)
    wr_reg(`PIC_ADDR_MASK, 32'h0040); rd_reg(`PIC_ADDR_CODE, d); `CHK("code", 32'h18, d)
    wr_reg(`PIC_ADDR_MASK, 32'h8000); rd_reg(`PIC_ADDR_PEND, d); `CHK("pend", 1'b1, d[15])
    go(1); pin_n <= 8'hFF; br <= 32'h0; go(16);
  endtask
  task automatic t_edge;
    wr_reg(`PIC_ADDR_TRIG, 32'h04); go(1); pin_n <= 8'hFB; go(4); pin_n <= 8'hFF; go(8);
    rd_reg(`PIC_ADDR_PEND, d); `CHK("pend", 1'b1, d[4])
    wr_reg(`PIC_ADDR_PEND, 32'h10); rd_reg(`PIC_ADDR_PEND, d); `CHK("pend", 1'b0, d[4])
  endtask
  // Half-rate bridge: level 0 is still clear at edge 12 and set by edge 14
  task automatic t_bridge;
    wr_reg(`PIC_ADDR_BRIDGE, 32'h1); go(1); br <= 32'h1; go(10);
    rd_reg(`PIC_ADDR_PEND, d); `CHK("pend_half_early", 1'b0, d[1])
    rd_reg(`PIC_ADDR_PEND, d); `CHK("pend_half", 1'b1, d[1])
    go(1); br <= 32'h0; wr_reg(`PIC_ADDR_BRIDGE, 32'h0); go(16);
  endtask
  task automatic t_entry;
    slow <= 1'b1; wr_reg(`PIC_ADDR_TRIG, 32'h0); wr_reg(`PIC_ADDR_MASK, 32'h0004);
    wr_reg(`PIC_ADDR_ENWR, 32'h0); rd_reg(`PIC_ADDR_STATE, d); `CHK("state", 32'h8002, d)
    go(1); pin_n <= 8'hFD; wait_load(`PIC_VEC_EXT);
    `CHK("ee", 1'b0, state_word[15])
    rd_reg(`PIC_ADDR_SRET, d); `CHK("sret", PC, d)
    rd_reg(`PIC_ADDR_SSTATE, d); `CHK("sstate", 32'h0000_8002, d)
    go(1); pin_n <= 8'hFF; go(8);
    ret <= 1'b1; go(1); ret <= 1'b0; wait_load(PC);
    rd_reg(`PIC_ADDR_STATE, d); `CHK("state", 32'h8002, d)
    wr_reg(`PIC_ADDR_OFFWR, 32'h0); rd_reg(`PIC_ADDR_STATE, d); `CHK("state", 32'h2, d)
    wr_reg(`PIC_ADDR_UNRWR, 32'h0); rd_reg(`PIC_ADDR_STATE, d); `CHK("state", 32'h0, d)
  endtask
  task automatic t_nmi;
    wr_reg(`PIC_ADDR_MASK, 32'h0); go(1); pin_n <= 8'hFE; wait_load(`PIC_VEC_NMI);
    rd_reg(`PIC_ADDR_SSTATE, d); `CHK("info", 16'h0001, d[31:16])
    go(1); pin_n <= 8'hFF; go(8);
  endtask
  initial begin
    go(20); reset_i <= 1'b0;
    t_reset; $display("test reset done");
    t_codes; $display("test codes done");
    t_prio; $display("test priority done");
    t_edge; $display("test edge done");
    t_bridge; $display("test bridge done");
    t_entry; $display("test entry done");
    t_nmi; $display("test nmi done");
    close_out();
  end
endmodule // prioritized_irq_controller_tb_top
